// [pmrb_pkg.sv]
// Purpose: Constants and types for the power, reset and boot block
// Assumes: mclk at 100 MHz, 32-bit classic Wishbone register port
// Notes on behaviour
// - Supply crossing the detection threshold sets the low-voltage flag until cleared.
// - The low-voltage flag is set out of power-up.
// - Flag set with its interrupt enable raises an interrupt to the core.
// - Protect option cleared blocks flash reads and writes while supply is low.
// - Reset-enable option cleared resets the device while supply is low.
// - Setting idle bit stops the core clock; peripherals keep clocking.
// - Enabled interrupt during idle clears idle bit and resumes the core.
// - Reset pin high during idle ends idle through hardware reset.
// - Three-bit select divides the idle clock by 1 to 128; default undivided.
// - Divided clock only while idle; undivided again as soon as idle ends.
// - Setting power-down bit stops the oscillator; register contents are kept.
// - Any internal reset (pin, watchdog, low supply, software) or either wake line ends power-down; pin restarts at zero.
// - Line wake holds the core clock for 32768 cycles, then vectors.
// - Power-on flag is set at power-on and stays until software clears it.
// - Baud doubler bit doubles the serial rate in serial modes 1 to 3.
// - Bit 6 of power control reads zero and cannot be set.
// - Reset sources: power-up, pin, watchdog, low supply, software request.
// - Power-up copies the stored boot select into the boot select bit.
// - Other resets use the current boot select bit without reloading.
// - Pin reset needs a high pulse of 10 us plus 36 oscillator cycles.
// - Boot select zero starts main memory; one starts programming memory.
package pmrb_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] PMRB_ADR_POWER_CONTROL = 8'h00;
  localparam logic [7:0] PMRB_ADR_IDLE_CLOCK = 8'h04;
  localparam logic [7:0] PMRB_ADR_AUX_CONTROL = 8'h08;
  localparam logic [7:0] PMRB_ADR_FLASH_PROG = 8'h0c;
  localparam logic [7:0] PMRB_ADR_RESET_CAUSE = 8'h10;
  // ==========================================================
  // Field positions
  localparam int PC_IDLE = 0;
  localparam int PC_PDOWN = 1;
  localparam int PC_GF0 = 2;
  localparam int PC_GF1 = 3;
  localparam int PC_POF = 4;
  localparam int PC_LVF = 5;
  localparam int PC_RSVD = 6;
  localparam int PC_BAUD = 7;
  localparam int AUX_LVIRQ = 2;
  localparam int FP_SWRST = 5;
  localparam int FP_BOOT = 6;
  localparam int DIV_SEL_W = 3;
  // Reset cause bit order: power-up, pin, watchdog, low supply, software
  localparam int RC_W = 5;
  localparam logic [RC_W-1:0] RC_POWER_UP = 5'h01;
  // ==========================================================
  // Reset values
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET = 3'h0;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PIN_PULSE_NS = 10000;
  localparam int PIN_PULSE_EXTRA = 36;
  localparam int PIN_PULSE_CYCLES = (PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                    + PIN_PULSE_EXTRA;
  localparam int WAKE_SETTLE_DEFAULT = 32768;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_DOWN, PM_SETTLE} pmrbPower_type;
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
  } pmrbWbReq_type;
  typedef struct packed {
    logic flashProtect;
    logic resetEnable;
    logic bootSelect;
  } pmrbNvOpt_type;
endpackage

// [pmrb_power_reset_boot.sv]
// Purpose: Power modes, low-supply flag, reset collection and boot choice
// Assumes: all inputs synchronous to mclk; rst is the power-up reset
// Notes: mclk is modelled as running in power-down; oscStop tells the pad
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module pmrb_power_reset_boot #(
  parameter int WAKE_SETTLE_CYCLES = pmrb_pkg::WAKE_SETTLE_DEFAULT
) (
  // Clock and power-up reset
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire pmrb_pkg::pmrbWbReq_type wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Analog detector, options and outside events
  input wire logic supplyLow,
  input wire pmrb_pkg::pmrbNvOpt_type nvOpt,
  input wire logic resetPin,
  input wire logic watchdogOverflow,
  input wire logic irqActive,
  input wire logic wakeLineA,
  input wire logic wakeLineB,
  // Clock controls and status to the core
  output logic cpuClockEn,
  output logic periphClockEn,
  output logic oscStop,
  output logic systemReset,
  output logic bootFromIsp,
  output logic flashBlock,
  output logic lowVoltageIrq,
  output logic baudDouble,
  output logic wakeVectorA,
  output logic wakeVectorB
);
  import pmrb_pkg::*;

  localparam int SETTLE_W = $clog2(WAKE_SETTLE_CYCLES + 1);
  localparam int PIN_W = $clog2(PIN_PULSE_CYCLES + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(WAKE_SETTLE_CYCLES - 1);
  localparam logic [PIN_W-1:0] PIN_LIMIT = PIN_W'(PIN_PULSE_CYCLES);

  // ==========================================================
  // Elaboration check; a zero count would never let the core restart
  // The upper bound keeps the settle counter within 21 bits
  if (WAKE_SETTLE_CYCLES < 1 || WAKE_SETTLE_CYCLES > 1048576) begin : gBadSettle
    $error("WAKE_SETTLE_CYCLES out of range");
  end

  // ==========================================================
  // State declarations
  pmrbPower_type pmState_q;
  logic idleReq_q;
  logic pdReq_q;
  logic lvFlag_q;
  logic porFlag_q;
  logic gf0_q;
  logic gf1_q;
  logic baud_q;
  logic lvIrqEn_q;
  logic [DIV_SEL_W-1:0] divSel_q;
  logic bootSel_q;
  logic bootLoad_q;
  logic swReset_q;
  logic [RC_W-1:0] resetCause_q;
  logic supplyLowPrev_q;
  logic [PIN_W-1:0] pinCnt_q;
  logic [SETTLE_W-1:0] settleCnt_q;
  logic wakeFromA_q;
  logic [6:0] divCnt_q;
  logic [31:0] rdData_d;
  logic wrAccess;
  logic wrPower;
  logic pinReset;
  logic lvReset;
  logic intReset;
  logic lvEvent;
  logic divTick;
  logic settleDone;

  // ==========================================================
  // Bus decode: a write lands on the edge where ack is seen
  // Only byte lane 0 holds register bits; upper lanes are ignored
  assign wrAccess = wbCyc && wbStb && wbReq.we && wbAck && wbReq.sel[0];
  assign wrPower = wrAccess && (wbReq.adr == PMRB_ADR_POWER_CONTROL);

  // ==========================================================
  // Reset sources
  // Qualified on the last edge of the minimum pulse, so a pulse of
  // exactly the minimum width still resets; the counter saturates above
  assign pinReset = resetPin && (pinCnt_q >= PIN_LIMIT - PIN_W'(1));
  assign lvReset = supplyLow && !nvOpt.resetEnable;
  assign intReset = pinReset || watchdogOverflow || lvReset || swReset_q;
  assign lvEvent = supplyLow && !supplyLowPrev_q;
  assign settleDone = (settleCnt_q == SETTLE_LAST);

  // Pin pulse qualifier; shorter glitches never reset the part
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinCnt_q <= '0;
    end else if (!resetPin) begin
      pinCnt_q <= '0;
    end else if (pinCnt_q != PIN_LIMIT) begin
      pinCnt_q <= pinCnt_q + PIN_W'(1);
    end
  end

  // Software reset request is a one-shot, bit reads back zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      swReset_q <= 1'b0;
    end else begin
      swReset_q <= wrAccess && (wbReq.adr == PMRB_ADR_FLASH_PROG) && wbReq.dat[FP_SWRST];
    end
  end

  // System reset output and the cause of the latest reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      systemReset <= 1'b1;
      resetCause_q <= RC_POWER_UP;
    end else begin
      systemReset <= intReset;
      if (intReset) begin
        resetCause_q <= {swReset_q, lvReset, watchdogOverflow, pinReset, 1'b0};
      end
    end
  end

  // ==========================================================
  // Boot select: stored option only at power-up, kept otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bootLoad_q <= 1'b1;
      bootSel_q <= 1'b0;
    end else begin
      bootLoad_q <= 1'b0;
      if (bootLoad_q) begin
        bootSel_q <= nvOpt.bootSelect;
      end else if (wrAccess && wbReq.adr == PMRB_ADR_FLASH_PROG) begin
        bootSel_q <= wbReq.dat[FP_BOOT];
      end
    end
  end

  // Boot entrance is latched while reset is applied
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bootFromIsp <= 1'b0;
    end else if (bootLoad_q) begin
      bootFromIsp <= nvOpt.bootSelect;
    end else if (intReset) begin
      bootFromIsp <= bootSel_q;
    end
  end

  // ==========================================================
  // Sticky flags: hardware set wins over a software clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvFlag_q <= 1'b1;
      porFlag_q <= 1'b1;
      supplyLowPrev_q <= 1'b0;
    end else begin
      supplyLowPrev_q <= supplyLow;
      if (lvEvent) begin
        lvFlag_q <= 1'b1;
      end else if (wrPower && !wbReq.dat[PC_LVF]) begin
        lvFlag_q <= 1'b0;
      end
      if (wrPower && !wbReq.dat[PC_POF]) begin
        porFlag_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Plain control bits; internal resets clear them, power-up too
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gf0_q <= 1'b0;
      gf1_q <= 1'b0;
      baud_q <= 1'b0;
      lvIrqEn_q <= 1'b0;
      divSel_q <= DIV_SEL_RESET;
    end else if (intReset) begin
      gf0_q <= 1'b0;
      gf1_q <= 1'b0;
      baud_q <= 1'b0;
      lvIrqEn_q <= 1'b0;
      divSel_q <= DIV_SEL_RESET;
    end else if (wrAccess) begin
      if (wbReq.adr == PMRB_ADR_POWER_CONTROL) begin
        gf0_q <= wbReq.dat[PC_GF0];
        gf1_q <= wbReq.dat[PC_GF1];
        baud_q <= wbReq.dat[PC_BAUD];
      end
      if (wbReq.adr == PMRB_ADR_AUX_CONTROL) begin
        lvIrqEn_q <= wbReq.dat[AUX_LVIRQ];
      end
      if (wbReq.adr == PMRB_ADR_IDLE_CLOCK) begin
        divSel_q <= wbReq.dat[DIV_SEL_W-1:0];
      end
    end
  end

  // ==========================================================
  // Power mode machine
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pmState_q <= PM_RUN;
      idleReq_q <= 1'b0;
      pdReq_q <= 1'b0;
      wakeFromA_q <= 1'b0;
    end else if (intReset) begin
      // Any internal reset (pin, watchdog, low supply, software) leaves every mode
      pmState_q <= PM_RUN;
      idleReq_q <= 1'b0;
      pdReq_q <= 1'b0;
    end else begin
      case (pmState_q)
        PM_RUN: begin
          if (wrPower && wbReq.dat[PC_PDOWN]) begin
            pdReq_q <= 1'b1;
            pmState_q <= PM_DOWN;
          end else if (wrPower && wbReq.dat[PC_IDLE]) begin
            idleReq_q <= 1'b1;
            pmState_q <= PM_IDLE;
          end
        end
        PM_IDLE: begin
          if (irqActive) begin
            idleReq_q <= 1'b0;
            pmState_q <= PM_RUN;
          end
        end
        PM_DOWN: begin
          // Wake lines are assumed enabled by software beforehand
          if (wakeLineA || wakeLineB) begin
            wakeFromA_q <= wakeLineA;
            pmState_q <= PM_SETTLE;
          end
        end
        PM_SETTLE: begin
          if (settleDone) begin
            pdReq_q <= 1'b0;
            pmState_q <= PM_RUN;
          end
        end
        default: begin
          pmState_q <= PM_RUN;
        end
      endcase
    end
  end

  // Settle counter runs only while waking from power-down
  // Cleared outside settle so every wake counts the full hold
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      settleCnt_q <= '0;
    end else if (pmState_q == PM_SETTLE && !intReset) begin
      settleCnt_q <= settleCnt_q + SETTLE_W'(1);
    end else begin
      settleCnt_q <= '0;
    end
  end

  // ==========================================================
  // Idle divider: free count restarted on each idle entry
  // One shared counter: a code change mid-idle only shifts the phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCnt_q <= '0;
    end else if (pmState_q == PM_IDLE) begin
      divCnt_q <= divCnt_q + 7'h01;
    end else begin
      divCnt_q <= '0;
    end
  end

  // Tick when all counter bits below the selected width are ones
  always_comb begin
    divTick = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(divSel_q) && !divCnt_q[i]) begin
        divTick = 1'b0;
      end
    end
  end

  // ==========================================================
  // Clock control outputs, all registered
  // Registered so the gating cells never see a glitch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpuClockEn <= 1'b0;
      periphClockEn <= 1'b0;
      oscStop <= 1'b0;
    end else begin
      cpuClockEn <= (pmState_q == PM_RUN) && !intReset;
      oscStop <= (pmState_q == PM_DOWN);
      case (pmState_q)
        PM_RUN: periphClockEn <= 1'b1;
        PM_IDLE: periphClockEn <= divTick;
        default: periphClockEn <= 1'b0;
      endcase
    end
  end

  // Wake vector pulses leave with the first running cycle
  // A reset in the last settle cycle wins over the vector
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wakeVectorA <= 1'b0;
      wakeVectorB <= 1'b0;
    end else begin
      wakeVectorA <= (pmState_q == PM_SETTLE) && settleDone && wakeFromA_q && !intReset;
      wakeVectorB <= (pmState_q == PM_SETTLE) && settleDone && !wakeFromA_q && !intReset;
    end
  end

  // ==========================================================
  // Status outputs toward core, flash sequencer and serial port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flashBlock <= 1'b0;
      lowVoltageIrq <= 1'b0;
      baudDouble <= 1'b0;
    end else begin
      flashBlock <= supplyLow && !nvOpt.flashProtect;
      lowVoltageIrq <= lvIrqEn_q && lvFlag_q;
      baudDouble <= baud_q;
    end
  end

  // ==========================================================
  // Read mux; unmapped addresses answer with zero
  // Reads have no side effects, so a repeated read is harmless
  always_comb begin
    rdData_d = 32'h0000_0000;
    case (wbReq.adr)
      PMRB_ADR_POWER_CONTROL: begin
        rdData_d[PC_IDLE] = idleReq_q;
        rdData_d[PC_PDOWN] = pdReq_q;
        rdData_d[PC_GF0] = gf0_q;
        rdData_d[PC_GF1] = gf1_q;
        rdData_d[PC_POF] = porFlag_q;
        rdData_d[PC_LVF] = lvFlag_q;
        rdData_d[PC_RSVD] = 1'b0;
        rdData_d[PC_BAUD] = baud_q;
      end
      PMRB_ADR_IDLE_CLOCK: rdData_d[DIV_SEL_W-1:0] = divSel_q;
      PMRB_ADR_AUX_CONTROL: rdData_d[AUX_LVIRQ] = lvIrqEn_q;
      PMRB_ADR_FLASH_PROG: rdData_d[FP_BOOT] = bootSel_q;
      PMRB_ADR_RESET_CAUSE: rdData_d[RC_W-1:0] = resetCause_q;
      default: rdData_d = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wbAck <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end else begin
      wbAck <= wbCyc && wbStb && !wbAck;
      if (wbCyc && wbStb && !wbAck) begin
        wbDatO <= rdData_d;
      end
    end
  end
endmodule

// [pmrb_checker.sv]
// Purpose: Port assertions for the power, reset and boot block
// Assumes: one mclk domain, rst async active high
// Notes: helper counters track pin pulse length and wake settle time
`timescale 1ns/1ps
module pmrb_checker
  import pmrb_pkg::*;
#(
  parameter int WAKE_SETTLE_CYCLES = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire pmrb_pkg::pmrbWbReq_type wbReq,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  // Events and options
  input wire logic supplyLow,
  input wire pmrb_pkg::pmrbNvOpt_type nvOpt,
  input wire logic resetPin,
  input wire logic watchdogOverflow,
  input wire logic irqActive,
  input wire logic wakeLineA,
  input wire logic wakeLineB,
  // Outputs under watch
  input wire logic cpuClockEn,
  input wire logic periphClockEn,
  input wire logic oscStop,
  input wire logic systemReset,
  input wire logic bootFromIsp,
  input wire logic flashBlock,
  input wire logic wakeVectorA,
  input wire logic wakeVectorB
);
  // ==========================================================
  // Helper state
  logic [10:0] pinCnt_q;
  logic [15:0] hold_q;
  logic cpuPrev_q;
  logic idle_q;
  logic wrPc;
  logic intRst;
  assign wrPc = wbAck && wbCyc && wbStb && wbReq.we && wbReq.sel[0]
                && wbReq.adr == PMRB_ADR_POWER_CONTROL;
  // Pin, watchdog and low-supply reset causes (not software), so mode checks stay quiet around resets
  assign intRst = watchdogOverflow || pinCnt_q >= 11'(PIN_PULSE_CYCLES - 1)
                  || (supplyLow && !nvOpt.resetEnable);
  // Consecutive pin-high edges, saturating at the qualifying width
  always_ff @(posedge mclk or posedge rst) begin
    if (rst || !resetPin) begin
      pinCnt_q <= '0;
    end else if (pinCnt_q < 11'(PIN_PULSE_CYCLES)) begin
      pinCnt_q <= pinCnt_q + 11'h1;
    end
  end
  // Cycles the core clock stays held once the oscillator restarts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst || oscStop || cpuClockEn) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_q + 16'h1;
    end
  end
  // Idle entered from run; left when the core clock comes back
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpuPrev_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      cpuPrev_q <= cpuClockEn;
      if (wrPc && wbReq.dat[PC_IDLE] && !wbReq.dat[PC_PDOWN] && cpuClockEn) begin
        idle_q <= 1'b1;
      end else if (systemReset || (cpuClockEn && !cpuPrev_q)) begin
        idle_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_lowv_reset: assert property (supplyLow && !nvOpt.resetEnable |=> systemReset)
    else $error("low supply gave no reset");
  a_wdog_reset: assert property (watchdogOverflow |=> systemReset)
    else $error("watchdog gave no reset");
  a_flash_block: assert property (supplyLow && !nvOpt.flashProtect |=> flashBlock)
    else $error("flash not blocked");
  a_pin_reset: assert property (resetPin && pinCnt_q == 11'(PIN_PULSE_CYCLES)
    |-> ##[1:2] systemReset)
    else $error("long pin pulse gave no reset");
  a_idle_entry: assert property (wrPc && wbReq.dat[PC_IDLE] && !wbReq.dat[PC_PDOWN]
    && cpuClockEn && !intRst |-> ##2 !cpuClockEn && !oscStop)
    else $error("idle write did not stop core");
  a_pd_entry: assert property (wrPc && wbReq.dat[PC_PDOWN] && cpuClockEn && !intRst
    |-> ##2 oscStop && !cpuClockEn)
    else $error("power-down write did not stop oscillator");
  a_pd_hold: assert property (oscStop && !wakeLineA && !wakeLineB && !intRst
    |=> oscStop)
    else $error("power-down left without wake source");
  a_settle_time: assert property (wakeVectorA || wakeVectorB
    |-> hold_q >= 16'(WAKE_SETTLE_CYCLES - 1) && hold_q <= 16'(WAKE_SETTLE_CYCLES + 1))
    else $error("wake vector outside settle count");
  a_idle_exit: assert property (idle_q && !cpuClockEn && irqActive && !intRst
    |-> ##[1:3] cpuClockEn)
    else $error("interrupt did not end idle");
  a_rsvd_zero: assert property (wbAck && !wbReq.we && wbReq.adr == PMRB_ADR_POWER_CONTROL
    |-> wbDatO[PC_RSVD] == 1'b0)
    else $error("reserved bit read as one");
  a_boot_load: assert property ($fell(rst) |=> bootFromIsp == nvOpt.bootSelect)
    else $error("boot select not loaded at power-up");
  a_run_periph: assert property (cpuClockEn |-> periphClockEn)
    else $error("peripheral clock divided while running");
  c_wake_a: cover property (wakeVectorA);
  c_wake_b: cover property (wakeVectorB);
  c_idle_irq: cover property (idle_q && irqActive);
endmodule

bind pmrb_power_reset_boot pmrb_checker #(.WAKE_SETTLE_CYCLES(WAKE_SETTLE_CYCLES)) chk_u (.*);

// [pmrb_far_side.sv]
// Purpose: Far-side model: interrupt source, reset pin and wake lines
// Assumes: tasks are entered just after a rising mclk edge
// Notes: a wake line drops once the core has taken its vector
`timescale 1ns/1ps
module pmrb_far_side (
  // Clock and core view
  input wire logic mclk,
  input wire logic cpuClockEn,
  input wire logic wakeVectorA,
  input wire logic wakeVectorB,
  // Lines toward the block
  output logic resetPin,
  output logic wakeLineA,
  output logic wakeLineB,
  output logic irqActive
);
  logic [1:0] lastVec = 2'h0;
  // Quiet lines from time zero
  initial begin
    resetPin = 1'b0;
    wakeLineA = 1'b0;
    wakeLineB = 1'b0;
    irqActive = 1'b0;
  end
  // Pin pulse of n cycles; only a long enough pulse may reset
  task automatic pinPulse(input int n);
    resetPin <= 1'b1;
    repeat (n) @(posedge mclk);
    resetPin <= 1'b0;
  endtask
  // Level request held until serviced, or given up after a while
  task automatic interrupt();
    int i;
    irqActive <= 1'b1;
    for (i = 0; i < 50 && cpuClockEn !== 1'b1; i++) @(posedge mclk);
    irqActive <= 1'b0;
  endtask
  // Wake only after the bench armed things; records the vector taken
  task automatic wake(input logic lineB);
    int i;
    lastVec = 2'h0;
    wakeLineA <= !lineB;
    wakeLineB <= lineB;
    for (i = 0; i < 200 && wakeVectorA !== 1'b1 && wakeVectorB !== 1'b1; i++) begin
      @(posedge mclk);
    end
    lastVec = {wakeVectorB, wakeVectorA};
    wakeLineA <= 1'b0;
    wakeLineB <= 1'b0;
  endtask
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the power, reset and boot block
// Assumes: settle count shortened to 8; stored options change only at the end
// Notes: the bus master waits on ack; every wait is bounded
`timescale 1ns/1ps
module testbench;
  import pmrb_pkg::*;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  pmrbWbReq_type wbReq = '0;
  logic supplyLow = 1'b0;
  pmrbNvOpt_type nvOpt = 3'h3;
  logic watchdogOverflow = 1'b0;
  logic [31:0] wbDatO;
  logic [31:0] rd;
  logic wbAck, resetPin, wakeLineA, wakeLineB, irqActive, cpuClockEn, periphClockEn;
  logic oscStop, systemReset, bootFromIsp, flashBlock, lowVoltageIrq, baudDouble;
  logic wakeVectorA, wakeVectorB;
  int badCount = 0;
  int nTests = 0;
  int n;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  pmrb_power_reset_boot #(.WAKE_SETTLE_CYCLES(8)) dut_u (.*);
  pmrb_far_side far_u (.*);
  // ==========================================================
  // Tasks
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; request held until ack is sampled
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int i;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbReq <= '{adr: a, dat: {24'h0, d}, sel: 4'hf, we: w};
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (wbAck !== 1'b1 && i < 50);
    if (wbAck !== 1'b1) begin
      badCount++;
      $display("mismatch at %0t: no ack", $time);
      finalReport();
    end
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdCheck(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 8'h00);
    check(rd, exp);
  endtask
  // Cycles from one peripheral tick to the next
  task automatic period(output int p);
    int i;
    for (i = 0; i < 300 && periphClockEn !== 1'b1; i++) @(posedge mclk);
    @(posedge mclk);
    p = 1;
    for (i = 0; i < 300 && periphClockEn !== 1'b1; i++) begin
      @(posedge mclk);
      p++;
    end
  endtask
  // Raise one reset source, see the reset come and go
  task automatic pulseSrc(input int k);
    int i;
    case (k)
      0: watchdogOverflow <= 1'b1;
      1: supplyLow <= 1'b1;
      default: xfer(PMRB_ADR_FLASH_PROG, 1'b1, 8'h60);
    endcase
    for (i = 0; i < 5 && systemReset !== 1'b1; i++) @(posedge mclk);
    check(systemReset, 1'b1);
    watchdogOverflow <= 1'b0;
    supplyLow <= 1'b0;
    for (i = 0; i < 5 && systemReset !== 1'b0; i++) @(posedge mclk);
    check(systemReset, 1'b0);
    rdCheck(PMRB_ADR_RESET_CAUSE, 32'h4 << k);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check(bootFromIsp, 1'b1);
    rdCheck(PMRB_ADR_POWER_CONTROL, 32'h30);
    rdCheck(PMRB_ADR_IDLE_CLOCK, 32'h0);
    rdCheck(PMRB_ADR_RESET_CAUSE, 32'(RC_POWER_UP));
    rdCheck(8'h14, 32'h0);
    xfer(PMRB_ADR_POWER_CONTROL, 1'b1, 8'hc0);
    repeat (2) @(posedge mclk);
    check(baudDouble, 1'b1);
    rdCheck(PMRB_ADR_POWER_CONTROL, 32'h80);
    xfer(PMRB_ADR_POWER_CONTROL, 1'b1, 8'h00);
    $display("test registers done");
    // Low supply sets the flag, raises the request, blocks flash
    xfer(PMRB_ADR_AUX_CONTROL, 1'b1, 8'h04);
    supplyLow <= 1'b1;
    repeat (3) @(posedge mclk);
    check(flashBlock, 1'b1);
    check(lowVoltageIrq, 1'b1);
    supplyLow <= 1'b0;
    repeat (3) @(posedge mclk);
    check(flashBlock, 1'b0);
    rdCheck(PMRB_ADR_POWER_CONTROL, 32'h20);
    xfer(PMRB_ADR_POWER_CONTROL, 1'b1, 8'h00);
    xfer(PMRB_ADR_AUX_CONTROL, 1'b1, 8'h00);
    $display("test low supply done");
    // Idle at every divider code, left by an interrupt
    for (int s = 0; s < 8; s++) begin
      xfer(PMRB_ADR_IDLE_CLOCK, 1'b1, 8'(s));
      xfer(PMRB_ADR_POWER_CONTROL, 1'b1, 8'h01);
      repeat (3) @(posedge mclk);
      check(cpuClockEn, 1'b0);
      period(n);
      check(n, 1 << s);
      far_u.interrupt();
      repeat (3) @(posedge mclk);
      check(periphClockEn, 1'b1);
      rdCheck(PMRB_ADR_POWER_CONTROL, 32'h0);
    end
    $display("test idle done");
    // Power-down ignores interrupts and short pin pulses, wakes by line
    for (int b = 0; b < 2; b++) begin
      xfer(PMRB_ADR_POWER_CONTROL, 1'b1, 8'h06);
      repeat (2) @(posedge mclk);
      check(oscStop, 1'b1);
      far_u.interrupt();
      far_u.pinPulse(100);
      check(oscStop, 1'b1);
      far_u.wake(b[0]);
      check(far_u.lastVec, b[0] ? 2'h2 : 2'h1);
      rdCheck(PMRB_ADR_POWER_CONTROL, 32'h4);
    end
    $display("test power-down done");
    // Pin reset out of idle keeps the boot select bit
    xfer(PMRB_ADR_FLASH_PROG, 1'b1, 8'h00);
    xfer(PMRB_ADR_POWER_CONTROL, 1'b1, 8'h01);
    far_u.pinPulse(PIN_PULSE_CYCLES - 4);
    repeat (3) @(posedge mclk);
    check(systemReset, 1'b0);
    far_u.pinPulse(PIN_PULSE_CYCLES + 4);
    check(systemReset, 1'b1);
    repeat (4) @(posedge mclk);
    check(cpuClockEn, 1'b1);
    check(bootFromIsp, 1'b0);
    rdCheck(PMRB_ADR_RESET_CAUSE, 32'h2);
    $display("test pin reset done");
    // Other reset sources; boot select set before them must survive
    nvOpt.resetEnable <= 1'b0;
    xfer(PMRB_ADR_FLASH_PROG, 1'b1, 8'h40);
    for (int k = 0; k < 3; k++) begin
      pulseSrc(k);
    end
    repeat (3) @(posedge mclk);
    check(bootFromIsp, 1'b1);
    $display("test reset sources done");
    finalReport();
  end
endmodule
